// *** hdl/acs_pkg.sv ***
// Package: constants, types and register map of the channel scan sequencer
package acs_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] ACS_OFF_CFG    = 4'h0;
    localparam logic [3:0] ACS_OFF_CTRL   = 4'h4;
    localparam logic [3:0] ACS_OFF_STATUS = 4'h8;
    localparam logic [3:0] ACS_OFF_STEP   = 4'hc;
    // ==========================================================
    // Configuration field positions
    localparam int ACS_CFG_SEL_LSB  = 0;  // chan_sel_bit3..0 at [3:0]
    localparam int ACS_CFG_SGL_BIT  = 4;  // single_vs_pseudo_diff
    localparam int ACS_CFG_SCAN_LSB = 5;  // scan_cfg_hi/lo at [6:5]
    localparam int ACS_CFG_REF_BIT  = 7;  // ref_pin_function
    localparam int ACS_CFG_EXT_BIT  = 8;  // external conversion clock
    localparam int ACS_CFG_VAR_LSB  = 9;  // variant at [10:9]
    // Control bits
    localparam int ACS_CTRL_START = 0;
    localparam int ACS_CTRL_NACK  = 1;
    localparam int ACS_CTRL_ACK   = 2;
    // ==========================================================
    // Reset values and counts
    localparam logic [10:0] ACS_CFG_RST    = 11'h410; // 12-in, SE, input 0, mode 00
    localparam logic [3:0]  ACS_REPEAT_CNT = 4'h8;
    localparam logic [3:0]  ACS_CH_TWO     = 4'h2;
    localparam logic [3:0]  ACS_CH_SIX     = 4'h6;
    localparam logic [3:0]  ACS_GND_CODE   = 4'hf;    // code meaning ground
    localparam logic [1:0]  ACS_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  ACS_RESP_SLVERR = 2'h2;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ACS_V4  = 2'b00,
        ACS_V8  = 2'b01,
        ACS_V12 = 2'b10
    } acs_variant_t;
    typedef enum logic [1:0] {
        ACS_SCAN_UP    = 2'b00,
        ACS_SCAN_EIGHT = 2'b01,
        ACS_SCAN_UPPER = 2'b10,
        ACS_SCAN_ONE   = 2'b11
    } acs_scan_t;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_STEP = 2'b01,
        ACS_WAIT = 2'b10
    } acs_state_t;
    // Input pair presented to the converter
    typedef struct packed {
        logic       valid;
        logic [3:0] pos;   // input number, ACS_GND_CODE for ground
        logic [3:0] neg;
    } acs_pair_t;
endpackage

// *** hdl/acs_sequencer.sv ***
// Module: channel scan sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Converter side
    output var  acs_pkg::acs_pair_t conv_pair,
    input  wire logic             conv_done
);
    import acs_pkg::*;

    // ==========================================================
    // Register state
    logic [10:0]  cfg_reg;
    acs_state_t   state_reg;
    logic [3:0]   code_reg;     // select code being converted
    logic [3:0]   count_reg;    // conversions finished in this scan
    logic         stop_reg;     // nack seen; ends an external-clock single-channel scan after current step
    logic         aw_got_reg;
    logic         w_got_reg;
    logic [3:0]   aw_addr_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         done_meta_reg;
    logic         done_sync_reg;
    logic         done_prev_reg;

    // ==========================================================
    // Configuration fields; variant forcing of select bits
    wire acs_variant_t var_sel  = acs_variant_t'(cfg_reg[ACS_CFG_VAR_LSB +: 2]);
    wire acs_scan_t    scan     = acs_scan_t'(cfg_reg[ACS_CFG_SCAN_LSB +: 2]);
    wire logic         sgl      = cfg_reg[ACS_CFG_SGL_BIT];
    wire logic         ref_fn   = cfg_reg[ACS_CFG_REF_BIT];
    wire logic         ext_clk  = cfg_reg[ACS_CFG_EXT_BIT];
    wire logic [3:0]   raw_sel  = cfg_reg[ACS_CFG_SEL_LSB +: 4];
    wire logic [3:0]   sel      = (var_sel == ACS_V4) ? {2'b00, raw_sel[1:0]} :
                                  (var_sel == ACS_V8) ? {1'b0, raw_sel[2:0]} :
                                  raw_sel;
    wire logic [3:0]   shared_ch = (var_sel == ACS_V4) ? 4'h3 : 4'hb;
    wire logic         has_shared = (var_sel != ACS_V8);

    // Pair decode of one select code
    function automatic acs_pair_t decode(input logic [3:0] c, input logic se,
                                         input logic rf, input logic [3:0] sh,
                                         input logic hs);
        acs_pair_t p;
        logic [3:0] even;
        logic [3:0] odd;
        p     = '0;
        even  = {c[3:1], 1'b0};
        odd   = {c[3:1], 1'b1};
        p.valid = 1'b1;
        if (se) begin
            p.pos = c;
            p.neg = ACS_GND_CODE;
        end else if (c[0]) begin
            p.pos = odd;
            p.neg = even;
        end else begin
            p.pos = even;
            p.neg = odd;
        end
        if (rf && hs && p.pos == sh)
            p.pos = ACS_GND_CODE;
        if (rf && hs && p.neg == sh)
            p.neg = ACS_GND_CODE;
        return p;
    endfunction

    // ==========================================================
    // Scan start and stepping
    wire logic [3:0] upper_first = (var_sel == ACS_V4) ? ACS_CH_TWO : ACS_CH_SIX;
    wire logic       pdiff_odd   = ~sgl & sel[0];
    wire logic [3:0] first_up    = sgl ? 4'h0 : {3'b000, pdiff_odd};
    wire logic [3:0] upper_base  = sgl ? upper_first : {upper_first[3:1], pdiff_odd};
    wire logic       one_chan    = (scan == ACS_SCAN_EIGHT) || (scan == ACS_SCAN_ONE);
    wire logic [3:0] first_code  = one_chan ? sel :
                                   (scan == ACS_SCAN_UP) ? first_up :
                                   upper_base;
    wire logic [3:0] last_code   = (scan == ACS_SCAN_UPPER && sel < upper_base) ?
                                   upper_base : sel;
    wire logic [3:0] step_inc    = sgl ? 4'h1 : 4'h2;
    wire logic [3:0] next_count  = count_reg + 4'h1;
    wire logic       done_pulse  = done_sync_reg & ~done_prev_reg;
    wire logic       scan_end    = ext_clk && one_chan ? stop_reg :
                                   (scan == ACS_SCAN_EIGHT) ? (next_count == ACS_REPEAT_CNT) :
                                   (scan == ACS_SCAN_ONE) ? 1'b1 :
                                   (code_reg >= last_code);

    // ==========================================================
    // AXI write path
    wire logic        wr_go   = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire logic        wr_cfg  = wr_go && aw_addr_reg == ACS_OFF_CFG;
    wire logic        wr_ctrl = wr_go && aw_addr_reg == ACS_OFF_CTRL;
    wire logic        wr_hit  = wr_cfg || wr_ctrl;
    wire logic        go_cmd   = wr_ctrl && w_strb_reg[0] && w_data_reg[ACS_CTRL_START];
    wire logic        nack_cmd = wr_ctrl && w_strb_reg[0] && w_data_reg[ACS_CTRL_NACK];
    wire logic        busy     = state_reg != ACS_IDLE;
    wire logic [10:0] cfg_wmask = {{3{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire logic [10:0] cfg_next  = (cfg_reg & ~cfg_wmask) | (w_data_reg[10:0] & cfg_wmask);

    // AXI read decode
    wire logic [31:0] rd_word =
        (s_axi_araddr == ACS_OFF_CFG)    ? {21'h000000, cfg_reg} :
        (s_axi_araddr == ACS_OFF_STATUS) ? {24'h000000, count_reg, 1'b0, stop_reg, state_reg} :
        (s_axi_araddr == ACS_OFF_STEP)   ? {23'h000000, conv_pair} :
        (s_axi_araddr == ACS_OFF_CTRL)   ? 32'h00000000 : 32'h00000000;
    wire logic        rd_hit = s_axi_araddr == ACS_OFF_CFG || s_axi_araddr == ACS_OFF_STATUS ||
                               s_axi_araddr == ACS_OFF_STEP || s_axi_araddr == ACS_OFF_CTRL;

    // Address and data capture, response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ACS_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ACS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Configuration register; held while a scan runs
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cfg_reg <= ACS_CFG_RST;
        else if (wr_cfg && !busy)
            cfg_reg <= cfg_next;
    end

    // Conversion-done input synchroniser and edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
            done_prev_reg <= 1'b0;
        end else begin
            done_meta_reg <= conv_done;
            done_sync_reg <= done_meta_reg;
            done_prev_reg <= done_sync_reg;
        end
    end

    // ==========================================================
    // Scan state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ACS_IDLE;
            code_reg  <= 4'h0;
            count_reg <= 4'h0;
            stop_reg  <= 1'b0;
            conv_pair <= '0;
        end else begin
            if (nack_cmd && busy)
                stop_reg <= 1'b1;
            case (state_reg)
                ACS_IDLE: begin
                    conv_pair <= '0;
                    if (go_cmd) begin
                        code_reg  <= first_code;
                        count_reg <= 4'h0;
                        stop_reg  <= 1'b0;
                        state_reg <= ACS_STEP;
                    end
                end
                ACS_STEP: begin
                    conv_pair <= decode(code_reg, sgl, ref_fn, shared_ch, has_shared);
                    state_reg <= ACS_WAIT;
                end
                ACS_WAIT: begin
                    if (done_pulse) begin
                        count_reg <= next_count;
                        if (scan_end) begin
                            state_reg <= ACS_IDLE;
                        end else begin
                            if (!one_chan)
                                code_reg <= code_reg + step_inc;
                            state_reg <= ACS_STEP;
                        end
                    end
                end
                default: state_reg <= ACS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** testbench/acs_conv_model.sv ***
// Model: converter answering each presented input pair with a done pulse
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Sequencer side
    input  wire acs_pkg::acs_pair_t conv_pair,
    output var  logic               conv_done,
    // Bench control: long conversion time
    input  wire logic               slow
);
    import acs_pkg::*;
    // Pairs converted since the bench last cleared the log
    logic [7:0] log_q[$];
    initial conv_done = 1'b0;
    // One conversion per presentation, done low again before the next
    always begin
        @(negedge aclk);
        if (aresetn === 1'b1 && conv_pair.valid === 1'b1) begin
            log_q.push_back({conv_pair.pos, conv_pair.neg});
            repeat (slow ? 12 : 1) @(posedge aclk);
            conv_done <= 1'b1;
            repeat (4) @(posedge aclk);
            conv_done <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    end
endmodule
`default_nettype wire

// *** testbench/acs_sequencer_properties.sv ***
// Checker: port-level properties of the channel scan sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_properties (
    // Clock and reset
    input wire logic               aclk,
    input wire logic               aresetn,
    // Register writes
    input wire logic [3:0]         s_axi_awaddr,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic [31:0]        s_axi_wdata,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    // Converter side
    input wire acs_pkg::acs_pair_t conv_pair
);
    import acs_pkg::*;
    // ==========================================================
    // Shadow configuration, taken from full writes while idle
    logic [10:0]     cfg_reg;
    wire logic       cv  = conv_pair.valid;
    wire logic [3:0] ps  = conv_pair.pos;
    wire logic [3:0] ng  = conv_pair.neg;
    wire logic       wr  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic       sgl = cfg_reg[ACS_CFG_SGL_BIT];
    wire logic       rf  = cfg_reg[ACS_CFG_REF_BIT];
    wire logic [1:0] sc  = cfg_reg[ACS_CFG_SCAN_LSB +: 2];
    wire logic [1:0] vr  = cfg_reg[ACS_CFG_VAR_LSB +: 2];
    wire logic [3:0] sh  = (vr == ACS_V4) ? 4'h3 : 4'hb;
    always_ff @(posedge aclk) begin
        if (!aresetn) cfg_reg <= ACS_CFG_RST;
        else if (wr && s_axi_awaddr == ACS_OFF_CFG && !cv) cfg_reg <= s_axi_wdata[10:0];
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_se_gnd; cv && sgl |-> ng == ACS_GND_CODE; endproperty
    a_se_gnd: assert property (p_se_gnd) else $error("pair not against ground");
    property p_pair; cv && !sgl && !rf |-> ps[3:1] == ng[3:1] && ps[0] != ng[0]; endproperty
    a_pair: assert property (p_pair) else $error("inputs not a pair");
    property p_force; cv && vr == ACS_V4 && ps != ACS_GND_CODE |-> ps[3:2] == 2'b00; endproperty
    a_force: assert property (p_force) else $error("select bits not forced");
    property p_se_ref; cv && sgl && rf && vr != ACS_V8 |-> ps != sh; endproperty
    a_se_ref: assert property (p_se_ref) else $error("shared pin not ground");
    property p_df_ref; cv && !sgl && rf && vr == ACS_V12 && ps == 4'ha |-> ng == 4'hf; endproperty
    a_df_ref: assert property (p_df_ref) else $error("shared pin not ground");
    property p_up; cv && $past(cv) && ps != $past(ps) && sc == ACS_SCAN_UP && sgl && !rf
        |-> ps == $past(ps) + 4'h1; endproperty
    a_up: assert property (p_up) else $error("scan not ascending");
    property p_upper; $rose(cv) && sc == ACS_SCAN_UPPER && vr != ACS_V4 |-> ps[3:1] == 3'h3; endproperty
    a_upper: assert property (p_upper) else $error("upper scan start wrong");
    property p_rst; disable iff (1'b0) !aresetn |=> !cv; endproperty
    a_rst: assert property (p_rst) else $error("pair valid after reset");
endmodule
bind acs_sequencer acs_sequencer_properties u_acs_sequencer_properties (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .conv_pair(conv_pair));
`default_nettype wire

// *** testbench/acs_sequencer_tb.sv ***
// Testbench: register-driven scan scenarios against a converter model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module acs_sequencer_tb;
    import acs_pkg::*;
    // ==========================================================
    // Signals
    logic       aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic       arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic       awready, wready, bvalid, arready, rvalid, conv_done;
    logic [1:0] bresp, rresp;
    acs_pair_t  conv_pair;
    int         errors = 0, comparisons = 0;
    logic [7:0] exp_q[$];
    // Clock, 40 ns period
    always #20 aclk = ~aclk;
    // ==========================================================
    // Design and converter model
    acs_sequencer u_acs_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conv_pair(conv_pair), .conv_done(conv_done));
    acs_conv_model u_acs_conv_model (.aclk(aclk), .aresetn(aresetn), .conv_pair(conv_pair),
        .conv_done(conv_done), .slow(slow));
    // ==========================================================
    // Bus tasks: hold each channel until its ready, then one idle edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK("write response", ACS_RESP_OKAY, bresp)
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Expected pair for one select code
    function automatic logic [7:0] pair_of(input logic [1:0] v, input logic sgl, input logic rf,
                                           input logic [3:0] c);
        logic [3:0] p, q, sh;
        p = c;
        q = sgl ? ACS_GND_CODE : (c ^ 4'h1);
        sh = (v == ACS_V4) ? 4'h3 : 4'hb;
        if (rf && v != ACS_V8 && p == sh) p = ACS_GND_CODE;
        if (rf && v != ACS_V8 && q == sh) q = ACS_GND_CODE;
        return {p, q};
    endfunction
    // One scan: configure, start, optionally end by not-acknowledge, compare pairs
    task automatic run(input logic [1:0] v, input logic sgl, input logic [1:0] sc,
                       input logic rf, input logic ext, input logic [3:0] sel);
        logic [3:0] s;
        logic [31:0] d;
        logic [1:0] r;
        int c, n;
        s = (v == ACS_V4) ? {2'b00, sel[1:0]} : (v == ACS_V8) ? {1'b0, sel[2:0]} : sel;
        exp_q.delete();
        if (sc[0]) begin
            for (c = 0; c < ((sc == ACS_SCAN_EIGHT && !ext) ? 8 : 1); c++)
                exp_q.push_back(pair_of(v, sgl, rf, s));
        end else begin
            c = ((sc == ACS_SCAN_UP) ? 0 : (v == ACS_V4) ? 2 : 6) + (sgl ? 0 : s[0]);
            do begin
                exp_q.push_back(pair_of(v, sgl, rf, c[3:0]));
                c += sgl ? 1 : 2;
            end while (c <= s);
        end
        slow <= ~slow;
        axi_wr(ACS_OFF_CFG, {21'h0, v, ext, rf, sc, sgl, sel});
        u_acs_conv_model.log_q.delete();
        axi_wr(ACS_OFF_CTRL, 32'h1);
        if (ext) begin
            while (u_acs_conv_model.log_q.size() < 3) @(posedge aclk);
            axi_wr(ACS_OFF_CTRL, 32'h2);
        end
        do begin
            axi_rd(ACS_OFF_STATUS, d, r);
        end while (d[1:0] !== 2'b00 || u_acs_conv_model.log_q.size() == 0);
        n = u_acs_conv_model.log_q.size();
        for (c = 0; c < n; c++)
            `CHK("pair", exp_q[ext ? 0 : c], u_acs_conv_model.log_q[c])
        `CHK("count ok", 1'b1, ext ? (n >= 3) : (n == exp_q.size()))
        `CHK("status count", 4'(n), d[7:4])
        `CHK("nack seen", ext, d[2])
        $display("scan done, %0d pairs", n);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ACS_OFF_CFG, d, r);
        `CHK("config", 32'h0000_0410, d)
        axi_rd(4'h2, d, r);
        `CHK("unmapped response", ACS_RESP_SLVERR, r)
        run(ACS_V12, 1'b1, ACS_SCAN_UP, 1'b0, 1'b0, 4'h3);
        run(ACS_V12, 1'b0, ACS_SCAN_UP, 1'b1, 1'b0, 4'ha);
        run(ACS_V12, 1'b0, ACS_SCAN_UP, 1'b1, 1'b0, 4'hb);
        run(ACS_V4, 1'b1, ACS_SCAN_UP, 1'b1, 1'b0, 4'hb);
        run(ACS_V8, 1'b1, ACS_SCAN_UPPER, 1'b1, 1'b0, 4'hb);
        run(ACS_V4, 1'b1, ACS_SCAN_UPPER, 1'b0, 1'b0, 4'h1);
        run(ACS_V4, 1'b0, ACS_SCAN_UPPER, 1'b0, 1'b0, 4'h3);
        run(ACS_V12, 1'b1, ACS_SCAN_UPPER, 1'b0, 1'b0, 4'h9);
        run(ACS_V12, 1'b1, ACS_SCAN_EIGHT, 1'b0, 1'b0, 4'h5);
        run(ACS_V12, 1'b0, ACS_SCAN_ONE, 1'b0, 1'b0, 4'h3);
        run(ACS_V8, 1'b1, ACS_SCAN_ONE, 1'b1, 1'b0, 4'h7);
        run(ACS_V12, 1'b1, ACS_SCAN_EIGHT, 1'b0, 1'b1, 4'h5);
        run(ACS_V12, 1'b0, ACS_SCAN_ONE, 1'b0, 1'b1, 4'h4);
        summarize();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
